// *** verilog/crcacc_pkg.sv ***
// Shared constants and types for the checksum/CRC accelerator
// How it works
// - Input words of 8, 16, 24 or 32 bits take one cycle per byte.
// - Width code 00/01/10/11 selects 8, 16, 24 or 32 input bits.
// - Reversal off passes bits straight; on mirrors them across the selected width.
// - Seeds written and results read are never bit-reversed.
// - Checksums add the previous carry unless carry discard is set.
// - With seed entry set, a completed data write loads the seed.
// - Algorithm 000 disables, 001 checksum8, 010 checksum32, 110 reserved.
// - Algorithm 011 is CRC-16 poly 0x8005, 100 is CRC-16 poly 0x1021.
// - Algorithm 101 is CRC-32 with polynomial 0x104C11DB7.
// - Writing 111 clears state to default seed and keeps the algorithm.
// - Busy reads one while a calculation is pending or running.
// - The result reads straight from the four data port bytes.
package crcacc_pkg;
   localparam logic [15:0] ADDR_CFG = 16'hA078;
   localparam logic [15:0] ADDR_B0 = 16'hA07C;
   localparam logic [15:0] ADDR_B1 = 16'hA07D;
   localparam logic [15:0] ADDR_B2 = 16'hA07E;
   localparam logic [15:0] ADDR_B3 = 16'hA07F;

   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_CHK8 = 3'h1;
   localparam logic [2:0] MODE_CHK32 = 3'h2;
   localparam logic [2:0] MODE_CRC16A = 3'h3;
   localparam logic [2:0] MODE_CRC16B = 3'h4;
   localparam logic [2:0] MODE_CRC32 = 3'h5;
   localparam logic [2:0] MODE_RSVD = 3'h6;
   localparam logic [2:0] MODE_CLEAR = 3'h7;

   localparam logic [31:0] POLY_CRC16A = 32'h0000_8005;
   localparam logic [31:0] POLY_CRC16B = 32'h0000_1021;
   localparam logic [31:0] POLY_CRC32 = 32'h04C1_1DB7;
   localparam logic [31:0] SEED_CHK = 32'h0000_0000;
   localparam logic [31:0] SEED_CRC16 = 32'h0000_FFFF;
   localparam logic [31:0] SEED_CRC32 = 32'hFFFF_FFFF;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int FIFO_DEPTH = 8;

   localparam logic [1:0] KIND_DATA = 2'h0;
   localparam logic [1:0] KIND_SEED = 2'h1;
   localparam logic [1:0] KIND_CLEAR = 2'h2;

   // Same layout for write; on read the mode field carries {0,0,busy}
   typedef struct packed {
      logic [1:0] width;
      logic reverse;
      logic discard;
      logic seed;
      logic [2:0] mode;
   } crcacc_cfg_t;

   typedef struct packed {
      logic [1:0] kind;
      logic [2:0] mode;
      logic [1:0] width;
      logic discard;
      logic [31:0] data;
   } crcacc_entry_t;

   typedef enum logic {ENG_IDLE, ENG_RUN} crcacc_state_t;
endpackage

// *** verilog/crcacc_fifo.sv ***
// Entry FIFO with registered output stage
`timescale 1ns/1ps
module crcacc_fifo #(
   parameter int W = 40,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q, rptr_q;
   logic [AW:0] cnt_q;
   logic valid_q;
   logic [W-1:0] data_q;
   logic push, load;

   assign in_ready = cnt_q != FULL_CNT;
   assign push = in_valid & in_ready;
   assign load = (cnt_q != '0) & (~valid_q | out_ready);
   assign out_valid = valid_q;
   assign out_data = data_q;
   assign empty = (cnt_q == '0) & ~valid_q;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         valid_q <= 1'b0;
         data_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (load) begin
            rptr_q <= rptr_q + 1'b1;
            data_q <= mem_q[rptr_q];
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
         if (load) begin
            valid_q <= 1'b1;
         end else if (out_ready) begin
            valid_q <= 1'b0;
         end
      end
   end
endmodule // crcacc_fifo

// *** verilog/crcacc_step.sv ***
// One byte of CRC, MSB first, 16 or 32 bit register
`timescale 1ns/1ps
module crcacc_step (
   // Operands
   input wire logic [31:0] crc_in,
   input wire logic [7:0] din,
   input wire logic [31:0] poly,
   input wire logic wide,
   // Result
   output logic [31:0] crc_out
);
   always_comb begin
      logic [31:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fb = (wide ? c[31] : c[15]) ^ din[i];
         c = {c[30:0], 1'b0};
         if (fb) begin
            c = c ^ poly;
         end
      end
      // Narrow CRC keeps the upper half clear for readback
      crc_out = wide ? c : {16'h0000, c[15:0]};
   end
endmodule // crcacc_step

// *** verilog/crcacc_top.sv ***
// Checksum/CRC accelerator with register port and entry FIFO
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module crcacc_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Register port
   input wire logic [15:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   output logic [7:0] REG_RDATA,
   // Status
   output logic ENTRY_READY,
   output logic BUSY
);
   localparam int EW = $bits(crcacc_pkg::crcacc_entry_t);

   crcacc_pkg::crcacc_cfg_t cfg_q, cfg_wr, cfg_rd;
   crcacc_pkg::crcacc_entry_t push_ent, f_ent, cur_q, ent;
   crcacc_pkg::crcacc_state_t state_q;
   logic [7:0] stg1_q, stg2_q, stg3_q, rdata_q, rdata_d;
   logic [31:0] res_q, res_d, raw_word, accel_data_port, engine_input_word;
   logic [31:0] crc_out, ent_data;
   logic [1:0] cnt_q, idx, bidx;
   logic [7:0] cur_byte;
   logic [8:0] sum8;
   logic [32:0] sum32;
   logic carry_q, carry_d, cin;
   logic sel_cfg, sel_b0, sel_b1, sel_b2, sel_b3;
   logic wr_cfg, wr_b0, clr_cmd, push_data, push_seed, push;
   logic f_valid, f_ready, f_empty, take, is_data, step, last;

   // Algorithms that consume data
   function automatic logic mode_computes(input logic [2:0] m);
      return (m == crcacc_pkg::MODE_CHK8) || (m == crcacc_pkg::MODE_CHK32) ||
             (m == crcacc_pkg::MODE_CRC16A) || (m == crcacc_pkg::MODE_CRC16B) ||
             (m == crcacc_pkg::MODE_CRC32);
   endfunction

   function automatic logic [31:0] width_mask(input logic [1:0] w);
      return crcacc_pkg::ALL_ONES >> {~w, 3'b000};
   endfunction

   function automatic logic [31:0] mirror(input logic [31:0] d, input logic [1:0] w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = d[31-i];
      end
      return r >> {~w, 3'b000};
   endfunction

   function automatic logic [31:0] poly_of(input logic [2:0] m);
      if (m == crcacc_pkg::MODE_CRC16A) begin
         return crcacc_pkg::POLY_CRC16A;
      end else if (m == crcacc_pkg::MODE_CRC16B) begin
         return crcacc_pkg::POLY_CRC16B;
      end else begin
         return crcacc_pkg::POLY_CRC32;
      end
   endfunction

   function automatic logic [31:0] seed_of(input logic [2:0] m);
      if (m == crcacc_pkg::MODE_CRC32) begin
         return crcacc_pkg::SEED_CRC32;
      end else if ((m == crcacc_pkg::MODE_CRC16A) || (m == crcacc_pkg::MODE_CRC16B)) begin
         return crcacc_pkg::SEED_CRC16;
      end else begin
         return crcacc_pkg::SEED_CHK;
      end
   endfunction

   // Address decode
   assign sel_cfg = REG_ADDR == crcacc_pkg::ADDR_CFG;
   assign sel_b0 = REG_ADDR == crcacc_pkg::ADDR_B0;
   assign sel_b1 = REG_ADDR == crcacc_pkg::ADDR_B1;
   assign sel_b2 = REG_ADDR == crcacc_pkg::ADDR_B2;
   assign sel_b3 = REG_ADDR == crcacc_pkg::ADDR_B3;
   assign wr_cfg = REG_WE & sel_cfg;
   assign wr_b0 = REG_WE & sel_b0;
   assign cfg_wr = crcacc_pkg::crcacc_cfg_t'(REG_WDATA);

   // Entry building; the low byte completes the word
   assign raw_word = {stg3_q, stg2_q, stg1_q, REG_WDATA};
   assign accel_data_port = raw_word & width_mask(cfg_q.width);
   assign engine_input_word = cfg_q.reverse ? mirror(raw_word, cfg_q.width) :
                              accel_data_port;
   assign clr_cmd = wr_cfg & (cfg_wr.mode == crcacc_pkg::MODE_CLEAR);
   assign push_data = wr_b0 & ~cfg_q.seed & mode_computes(cfg_q.mode);
   assign push_seed = wr_b0 & cfg_q.seed;
   assign push = push_data | push_seed | clr_cmd;
   // Seeds bypass the mirror
   assign push_ent.kind = clr_cmd ? crcacc_pkg::KIND_CLEAR :
                          push_seed ? crcacc_pkg::KIND_SEED : crcacc_pkg::KIND_DATA;
   assign push_ent.mode = cfg_q.mode;
   assign push_ent.width = cfg_q.width;
   assign push_ent.discard = cfg_q.discard;
   assign push_ent.data = push_data ? engine_input_word : raw_word;

   // Entries carry their own settings so later config writes cannot disturb them
   crcacc_fifo #(
      .W(EW),
      .DEPTH(crcacc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(MCLK),
      .rst(RST),
      .in_valid(push),
      .in_ready(ENTRY_READY),
      .in_data(push_ent),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_ent),
      .empty(f_empty)
   );

   // Engine selection: first byte straight from the FIFO head
   assign f_ready = state_q == crcacc_pkg::ENG_IDLE;
   assign take = f_ready & f_valid;
   assign ent = (state_q == crcacc_pkg::ENG_RUN) ? cur_q : f_ent;
   assign ent_data = ent.data;
   assign idx = (state_q == crcacc_pkg::ENG_RUN) ? cnt_q : 2'd0;
   assign is_data = ent.kind == crcacc_pkg::KIND_DATA;
   assign step = (state_q == crcacc_pkg::ENG_RUN) | (take & is_data);
   assign last = idx == ent.width;
   assign bidx = ent.width - idx;
   assign cur_byte = 8'(ent.data >> {bidx, 3'b000});
   assign cin = ent.discard ? 1'b0 : carry_q;
   assign sum8 = {1'b0, res_q[7:0]} + {1'b0, cur_byte} + {8'h00, cin};
   assign sum32 = {1'b0, res_q} + {1'b0, ent.data} + {32'h0, cin};

   crcacc_step u_step (
      .crc_in(res_q),
      .din(cur_byte),
      .poly(poly_of(ent.mode)),
      .wide(ent.mode == crcacc_pkg::MODE_CRC32),
      .crc_out(crc_out)
   );

   always_comb begin
      res_d = res_q;
      carry_d = carry_q;
      case (ent.mode)
         crcacc_pkg::MODE_CHK8: begin
            res_d = {24'h00_0000, sum8[7:0]};
            carry_d = sum8[8];
         end
         // Whole word added once, at the word's last byte cycle
         crcacc_pkg::MODE_CHK32: begin
            if (last) begin
               res_d = sum32[31:0];
               carry_d = sum32[32];
            end
         end
         crcacc_pkg::MODE_CRC16A, crcacc_pkg::MODE_CRC16B, crcacc_pkg::MODE_CRC32: begin
            res_d = crc_out;
         end
         default: begin
            res_d = res_q;
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         res_q <= '0;
         carry_q <= 1'b0;
      end else if (take & (f_ent.kind == crcacc_pkg::KIND_SEED)) begin
         res_q <= f_ent.data;
         carry_q <= 1'b0;
      end else if (take & (f_ent.kind == crcacc_pkg::KIND_CLEAR)) begin
         res_q <= seed_of(f_ent.mode);
         carry_q <= 1'b0;
      end else if (step) begin
         res_q <= res_d;
         carry_q <= carry_d;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= crcacc_pkg::ENG_IDLE;
         cnt_q <= 2'd0;
         cur_q <= '0;
      end else begin
         case (state_q)
            crcacc_pkg::ENG_IDLE: begin
               if (take & is_data & ~last) begin
                  state_q <= crcacc_pkg::ENG_RUN;
                  cnt_q <= 2'd1;
                  cur_q <= f_ent;
               end
            end
            crcacc_pkg::ENG_RUN: begin
               if (last) begin
                  state_q <= crcacc_pkg::ENG_IDLE;
               end else begin
                  cnt_q <= cnt_q + 2'd1;
               end
            end
            default: begin
               state_q <= crcacc_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   // Config and staging registers; mode ignores clear and reserved codes
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cfg_q <= crcacc_pkg::crcacc_cfg_t'(crcacc_pkg::CFG_RESET);
         stg1_q <= crcacc_pkg::BYTE_RESET;
         stg2_q <= crcacc_pkg::BYTE_RESET;
         stg3_q <= crcacc_pkg::BYTE_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q.width <= cfg_wr.width;
            cfg_q.reverse <= cfg_wr.reverse;
            cfg_q.discard <= cfg_wr.discard;
            cfg_q.seed <= cfg_wr.seed;
            if ((cfg_wr.mode != crcacc_pkg::MODE_CLEAR) &&
                (cfg_wr.mode != crcacc_pkg::MODE_RSVD)) begin
               cfg_q.mode <= cfg_wr.mode;
            end
         end
         if (REG_WE & sel_b1) begin
            stg1_q <= REG_WDATA;
         end
         if (REG_WE & sel_b2) begin
            stg2_q <= REG_WDATA;
         end
         if (REG_WE & sel_b3) begin
            stg3_q <= REG_WDATA;
         end
      end
   end

   // Read path; unmapped and idle cycles read zero
   assign BUSY = ~f_empty | (state_q == crcacc_pkg::ENG_RUN);
   assign cfg_rd.width = cfg_q.width;
   assign cfg_rd.reverse = cfg_q.reverse;
   assign cfg_rd.discard = cfg_q.discard;
   assign cfg_rd.seed = cfg_q.seed;
   assign cfg_rd.mode = {2'b00, BUSY};
   assign rdata_d = ~REG_RE ? 8'h00 :
                    sel_cfg ? 8'(cfg_rd) :
                    sel_b0 ? res_q[7:0] :
                    sel_b1 ? res_q[15:8] :
                    sel_b2 ? res_q[23:16] :
                    sel_b3 ? res_q[31:24] : 8'h00;
   assign REG_RDATA = rdata_q;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   sequence s_take_w(logic [1:0] w);
      take && is_data && (f_ent.width == w);
   endsequence

   sequence s_run_then_idle;
      (state_q == crcacc_pkg::ENG_RUN) ##1 (state_q == crcacc_pkg::ENG_IDLE);
   endsequence

   property p_len8;
      @(posedge MCLK) disable iff (RST)
      s_take_w(2'd0) |=> (state_q == crcacc_pkg::ENG_IDLE);
   endproperty
   a_len8: assert property (p_len8) else $error("8-bit entry not done in one cycle");

   property p_len16;
      @(posedge MCLK) disable iff (RST)
      s_take_w(2'd1) |=> s_run_then_idle;
   endproperty
   a_len16: assert property (p_len16) else $error("16-bit entry not two cycles");

   property p_len32;
      @(posedge MCLK) disable iff (RST)
      s_take_w(2'd3) |=> (state_q == crcacc_pkg::ENG_RUN)[*2] ##1 s_run_then_idle;
   endproperty
   a_len32: assert property (p_len32) else $error("32-bit entry not four cycles");

   property p_clear;
      @(posedge MCLK) disable iff (RST)
      take && (f_ent.kind == crcacc_pkg::KIND_CLEAR) && (f_ent.mode == crcacc_pkg::MODE_CRC32)
      |=> (res_q == crcacc_pkg::SEED_CRC32) && !carry_q;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not restore CRC seed");

   property p_clear_keep;
      @(posedge MCLK) disable iff (RST)
      clr_cmd |=> (cfg_q.mode == $past(cfg_q.mode));
   endproperty
   a_clear_keep: assert property (p_clear_keep) else $error("clear changed algorithm");

   property p_seed;
      @(posedge MCLK) disable iff (RST)
      take && (f_ent.kind == crcacc_pkg::KIND_SEED) |=> (res_q == $past(ent_data));
   endproperty
   a_seed: assert property (p_seed) else $error("seed not loaded");

   property p_off;
      @(posedge MCLK) disable iff (RST)
      wr_b0 && (cfg_q.mode == crcacc_pkg::MODE_OFF) && !cfg_q.seed |-> !push;
   endproperty
   a_off: assert property (p_off) else $error("disabled engine accepted data");

   property p_busy;
      @(posedge MCLK) disable iff (RST)
      push && ENTRY_READY |=> BUSY ##1 BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low with work pending");

   property p_rdres;
      @(posedge MCLK) disable iff (RST)
      REG_RE && sel_b0 |=> (REG_RDATA == 8'($past(res_q)));
   endproperty
   a_rdres: assert property (p_rdres) else $error("result byte readback wrong");

   property p_rev;
      @(posedge MCLK) disable iff (RST)
      push_data && cfg_q.reverse && (cfg_q.width == 2'd3)
      |-> (push_ent.data[31] == REG_WDATA[0]) && (push_ent.data[0] == stg3_q[7]);
   endproperty
   a_rev: assert property (p_rev) else $error("mirror across width wrong");
endmodule // crcacc_top

// *** dv/crcacc_cpu_model.sv ***
// CPU-side register master that drives the accelerator's register port
`timescale 1ns/1ps
module crcacc_cpu_model (
   // Clock
   input wire logic clk,
   // Register port
   output logic [15:0] addr,
   output logic [7:0] wdata,
   output logic we,
   output logic re,
   input wire logic [7:0] rdata
);
   initial begin
      addr = 16'h0000;
      wdata = 8'h00;
      we = 1'b0;
      re = 1'b0;
   end
   // Strobe held for back-to-back writes; idle drops it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
   endtask
   task automatic idle;
      we <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Low byte last, since it launches the calculation
   task automatic wr_word(input logic [31:0] w);
      wr(crcacc_pkg::ADDR_B3, w[31:24]);
      wr(crcacc_pkg::ADDR_B2, w[23:16]);
      wr(crcacc_pkg::ADDR_B1, w[15:8]);
      wr(crcacc_pkg::ADDR_B0, w[7:0]);
      idle;
   endtask
endmodule // crcacc_cpu_model

// *** dv/crcacc_top_test.sv ***
// Self-checking bench for the checksum/CRC accelerator
`timescale 1ns/1ps
module crcacc_top_test;
   logic mclk;
   logic rst;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_we;
   logic reg_re;
   logic [7:0] reg_rdata;
   logic entry_ready;
   logic busy;
   int num_errors = 0;
   int num_checks = 0;
   int nb;
   // Push to engine start goes through the FIFO and its output stage
   localparam int FIFO_LEAD = 2;
   logic [31:0] er;
   logic cy;
   logic [2:0] cm;
   crcacc_pkg::crcacc_cfg_t cf;

   always #4 mclk = ~mclk;

   crcacc_top DUT (.MCLK(mclk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .ENTRY_READY(entry_ready),
      .BUSY(busy));
   crcacc_cpu_model cpu (.clk(mclk), .addr(reg_addr), .wdata(reg_wdata), .we(reg_we),
      .re(reg_re), .rdata(reg_rdata));

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Own reference: MSB-first byte step, 16-bit result kept in the low half
   function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] b,
      input logic [31:0] p, input logic wide);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = (wide ? c[31] : c[15]) ^ b[i];
         c = c << 1;
         if (fb) begin
            c = c ^ p;
         end
      end
      return wide ? c : {16'h0000, c[15:0]};
   endfunction

   task automatic ref_push(input logic [31:0] w);
      logic [31:0] m;
      logic [31:0] p;
      logic [32:0] s;
      int n;
      n = int'(cf.width) + 1;
      m = (n == 4) ? w : w & ((32'h0000_0001 << (8 * n)) - 32'h0000_0001);
      if (cf.reverse) begin
         m = {<<{m}};
         m = m >> (32 - 8 * n);
      end
      p = (cm == crcacc_pkg::MODE_CRC16A) ? crcacc_pkg::POLY_CRC16A :
         (cm == crcacc_pkg::MODE_CRC16B) ? crcacc_pkg::POLY_CRC16B : crcacc_pkg::POLY_CRC32;
      if (cf.seed) begin
         er = w;
      end else if (cm == crcacc_pkg::MODE_CHK8) begin
         for (int k = n - 1; k >= 0; k--) begin
            s = 33'(er[7:0]) + 33'(m[8*k+:8]) + 33'(cy & ~cf.discard);
            er[7:0] = s[7:0];
            cy = s[8];
         end
      end else if (cm == crcacc_pkg::MODE_CHK32) begin
         s = 33'(er) + 33'(m) + 33'(cy & ~cf.discard);
         er = s[31:0];
         cy = s[32];
      end else if (cm != crcacc_pkg::MODE_OFF) begin
         for (int k = n - 1; k >= 0; k--) begin
            er = crc_b(er, m[8*k+:8], p, cm == crcacc_pkg::MODE_CRC32);
         end
      end
   endtask

   // Bounded wait; nb returns the cycles spent busy
   task automatic wait_idle;
      nb = 0;
      #1;
      while (busy !== 1'b0 && nb < 40) begin
         @(posedge mclk);
         #1;
         nb++;
      end
      if (nb >= 40) begin
         num_errors++;
         $display("Error busy expected 0 seen %b", busy);
      end
   endtask

   task automatic check_res;
      logic [7:0] b;
      logic [31:0] r;
      logic [31:0] mk;
      mk = (cm == crcacc_pkg::MODE_CHK8) ? 32'h0000_00FF :
         (cm == crcacc_pkg::MODE_CRC16A || cm == crcacc_pkg::MODE_CRC16B) ? 32'h0000_FFFF :
         crcacc_pkg::ALL_ONES;
      for (int i = 0; i < 4; i++) begin
         cpu.rd(crcacc_pkg::ADDR_B0 + 16'(i), b);
         r[8*i+:8] = b;
      end
      chk("result", er & mk, r & mk);
   endtask

   task automatic cfg(input logic [1:0] w, input logic r, d, s, input logic [2:0] md);
      logic [7:0] rb;
      cf = '{width: w, reverse: r, discard: d, seed: s, mode: md};
      cpu.wr(crcacc_pkg::ADDR_CFG, cf);
      cpu.idle;
      if (md == crcacc_pkg::MODE_CLEAR) begin
         er = (cm == crcacc_pkg::MODE_CRC32) ? crcacc_pkg::SEED_CRC32 :
            (cm == crcacc_pkg::MODE_CRC16A || cm == crcacc_pkg::MODE_CRC16B) ?
            crcacc_pkg::SEED_CRC16 : crcacc_pkg::SEED_CHK;
         cy = 1'b0;
      end else if (md != crcacc_pkg::MODE_RSVD) begin
         cm = md;
      end
      wait_idle;
      cpu.rd(crcacc_pkg::ADDR_CFG, rb);
      chk("config", {24'h00_0000, w, r, d, s, 3'b000}, {24'h00_0000, rb});
   endtask

   task automatic push(input logic [31:0] w);
      cpu.wr_word(w);
      wait_idle;
      ref_push(w);
   endtask

   // Reset values, reserved addresses in the window, write to a hole
   task automatic t_regs;
      logic [7:0] rb;
      cpu.wr(16'hA079, 8'hFF);
      cpu.idle;
      for (int i = 0; i < 8; i++) begin
         cpu.rd(16'hA078 + 16'(i), rb);
         chk("reset read", 32'h0000_0000, {24'h00_0000, rb});
      end
      chk("ready at reset", 32'h0000_0001, {31'h0000_0000, entry_ready});
   endtask

   task automatic t_widths;
      cfg(2'b00, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_CRC32);
      for (int w = 0; w < 4; w++) begin
         for (int r = 0; r < 2; r++) begin
            cfg(2'(w), 1'(r), 1'b0, 1'b0, crcacc_pkg::MODE_CLEAR);
            push(32'hA5C3_1E69);
            chk("busy cycles", 32'(FIFO_LEAD + w), 32'(nb));
            check_res;
         end
      end
   endtask

   task automatic t_chk;
      logic [1:0] w;
      logic [2:0] md;
      for (int i = 0; i < 4; i++) begin
         w = (i < 2) ? 2'b00 : 2'b11;
         md = (i < 2) ? crcacc_pkg::MODE_CHK8 : crcacc_pkg::MODE_CHK32;
         cfg(w, 1'b0, 1'(i % 2), 1'b0, md);
         cfg(w, 1'b0, 1'(i % 2), 1'b0, crcacc_pkg::MODE_CLEAR);
         push(32'hFFFF_FFF0);
         check_res;
         push(32'h0000_0020);
         check_res;
         push(32'h0000_0001);
         check_res;
      end
   endtask

   task automatic t_crc16;
      logic [2:0] md;
      for (int i = 0; i < 2; i++) begin
         md = (i == 0) ? crcacc_pkg::MODE_CRC16A : crcacc_pkg::MODE_CRC16B;
         cfg(2'b01, 1'b1, 1'b0, 1'b1, md);
         push(32'h1234_ABCD);
         check_res;
         cfg(2'b01, 1'b1, 1'b0, 1'b0, md);
         push(32'h0000_3C5A);
         check_res;
         cfg(2'b01, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_CLEAR);
         check_res;
         push(32'h0000_0102);
         check_res;
      end
   endtask

   // Back-to-back low-byte writes overrun the engine until the FIFO refuses
   task automatic t_fill;
      logic ok;
      logic [7:0] rb;
      int n;
      cfg(2'b11, 1'b1, 1'b0, 1'b1, crcacc_pkg::MODE_CRC32);
      push(32'h1234_5678);
      check_res;
      cfg(2'b11, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_CRC32);
      cpu.wr(crcacc_pkg::ADDR_B3, 8'h11);
      cpu.wr(crcacc_pkg::ADDR_B2, 8'h22);
      cpu.wr(crcacc_pkg::ADDR_B1, 8'h33);
      ok = 1'b1;
      n = 0;
      while (ok && n < 16) begin
         #1;
         ok = entry_ready;
         cpu.wr(crcacc_pkg::ADDR_B0, 8'(n));
         if (ok) begin
            ref_push({24'h11_2233, 8'(n)});
         end
         n++;
      end
      cpu.idle;
      chk("fifo refused", 32'h0000_0000, 32'(ok));
      cpu.rd(crcacc_pkg::ADDR_CFG, rb);
      chk("busy bit", 32'h0000_0001, {31'h0000_0000, rb[0]});
      wait_idle;
      chk("ready after drain", 32'h0000_0001, {31'h0000_0000, entry_ready});
      check_res;
   endtask

   task automatic t_off;
      cfg(2'b00, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_CRC32);
      cfg(2'b00, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_CLEAR);
      check_res;
      cfg(2'b00, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_RSVD);
      push(32'h0000_0055);
      check_res;
      cfg(2'b00, 1'b0, 1'b0, 1'b0, crcacc_pkg::MODE_OFF);
      push(32'h0000_0055);
      check_res;
   endtask

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      er = 32'h0000_0000;
      cy = 1'b0;
      cm = crcacc_pkg::MODE_OFF;
      cf = 8'h00;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_regs;
      t_widths;
      t_chk;
      t_crc16;
      t_fill;
      t_off;
      stop_test;
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      num_errors++;
      $display("Error watchdog expected done seen timeout");
      stop_test;
   end
endmodule // crcacc_top_test
